// ### hw/interrupt_entry_exit_control.v
`timescale 1ns/1ps
`default_nettype none
`include "intr_entry_exit_defs.vh"

module interrupt_entry_exit_control #(
  parameter LEVELS = 24
) (
  input wire MCLK_IN,
  input wire RST_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [11:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output wire PREADY_OUT,
  output wire PSLVERR_OUT,
  input wire [LEVELS-1:0] LEVEL_ENABLE_IN,
  input wire [LEVELS-1:0] LEVEL_ACTIVATE_IN,
  input wire [7:0] TRAP_TRIGGER_IN,
  output wire [LEVELS-1:0] LEVEL_ACTIVE_OUT,
  output wire [7:0] TRAP_ACTIVE_OUT,
  output wire EXT_BLOCK_OUT,
  output wire HOLD_OUT,
  output wire USER_MODE_OUT,
  output wire [3:0] CC_OUT
);

  reg [23:0] oper_ff;
  reg [23:0] index_i_ff;
  reg [23:0] index_j_ff;
  reg [23:0] index_k_ff;
  reg aem_ff;
  reg user_ff;
  reg [3:0] cc_ff;
  reg hold_ff;
  reg block_ff;
  reg rel_pend_ff;
  reg err_ff;
  reg [23:0] save_ff;
  reg [23:0] pc_ff;
  reg [LEVELS-1:0] active_ff;
  reg [7:0] trap_pend_ff;
  reg [7:0] trap_act_ff;
  reg [31:0] rd_mux;

  reg nxt_aem, nxt_user, nxt_hold, nxt_block, nxt_rel_pend, nxt_err;
  reg [3:0] nxt_cc;
  reg [23:0] nxt_save, nxt_pc;
  reg [LEVELS-1:0] clr_level;
  reg [7:0] clr_trap;
  reg [23:0] ea;
  reg [23:0] xval;
  reg any_other;
  integer k;

  wire wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
  wire cmd_wr = wr_en & (PADDR_IN == `REG_CMD);
  wire [3:0] op = PWDATA_IN[`CMD_OP_HI:`CMD_OP_LO];
  wire ind = PWDATA_IN[`CMD_IND_BIT];
  wire ext = PWDATA_IN[`CMD_EXT_BIT];
  wire idx = PWDATA_IN[`CMD_IDX_BIT];
  wire [1:0] xsel = PWDATA_IN[`CMD_XSEL_HI:`CMD_XSEL_LO];
  wire [LEVELS-1:0] act_en = active_ff & LEVEL_ENABLE_IN;
  wire [7:0] trap_unheld = trap_act_ff & ~`TRAP_HELD_MASK;

  // Single-cycle slave; an address above REG_INDEX is flagged
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & (PADDR_IN > `REG_INDEX);

  assign LEVEL_ACTIVE_OUT = active_ff;
  assign TRAP_ACTIVE_OUT = trap_act_ff;
  assign EXT_BLOCK_OUT = hold_ff | block_ff | rel_pend_ff;
  assign HOLD_OUT = hold_ff;
  assign USER_MODE_OUT = user_ff;
  assign CC_OUT = cc_ff;

  always @* begin
    nxt_aem = aem_ff;
    nxt_user = user_ff;
    nxt_cc = cc_ff;
    nxt_hold = hold_ff;
    nxt_block = block_ff;
    nxt_rel_pend = 1'b0;
    nxt_err = err_ff;
    nxt_save = save_ff;
    nxt_pc = pc_ff;
    clr_level = {LEVELS{1'b0}};
    clr_trap = 8'h00;
    xval = 24'h000000;
    any_other = 1'b0;
    k = 0;
    ea = (idx & ind) ? (oper_ff + index_k_ff) : oper_ff;
    if (!aem_ff) begin
      ea = {8'h00, ea[`CM_RA_HI:0]};
    end
    if (wr_en && PADDR_IN == `REG_CTRL) begin
      nxt_aem = PWDATA_IN[`CTRL_AEM_BIT];
      nxt_user = PWDATA_IN[`CTRL_USER_BIT];
      nxt_cc = PWDATA_IN[`CTRL_CC_HI:`CTRL_CC_LO];
    end
    if (cmd_wr) begin
      nxt_err = 1'b0;
      nxt_block = 1'b1;
      case (op)
        `OP_SAVE_LONG: begin
          if (!aem_ff) begin
            nxt_save = {3'h0, user_ff, cc_ff, pc_ff[`CM_RA_HI:0]};
          end else begin
            nxt_save = {4'h0, pc_ff[`AE_RA_HI:0]};
          end
          nxt_pc = ea + 24'h000001;
        end
        `OP_SAVE_EXT: begin
          if (!ext) begin
            nxt_err = 1'b1;
            nxt_block = block_ff;
          end else begin
            if (aem_ff) begin
              nxt_save = {cc_ff, pc_ff[`AE_RA_HI:0]};
            end else begin
              nxt_save = {3'h0, user_ff, cc_ff, pc_ff[`CM_RA_HI:0]};
            end
            nxt_pc = ea + 24'h000001;
          end
        end
        `OP_RESET_BRANCH: begin
          for (k = LEVELS - 1; k >= 0; k = k - 1) begin
            if (act_en[k]) begin
              clr_level = {LEVELS{1'b0}};
              clr_level[k] = 1'b1;
            end
          end
          if (hold_ff) begin
            clr_level = {LEVELS{1'b0}};
          end
          for (k = 7; k >= 0; k = k - 1) begin
            if (trap_unheld[k]) begin
              clr_trap = 8'h00;
              clr_trap[k] = 1'b1;
            end
          end
          any_other = |(act_en & ~clr_level);
          if (!ind) begin
            nxt_pc = ea;
          end else if (!aem_ff) begin
            nxt_cc = oper_ff[`CM_CC_HI:`CM_CC_LO];
            nxt_pc = {8'h00, oper_ff[`CM_RA_HI:0]};
            if (!user_ff) begin
              nxt_user = oper_ff[`CM_USER_BIT];
            end
          end else begin
            nxt_cc = oper_ff[`AE_CC_HI:`AE_CC_LO];
            nxt_pc = {4'h0, oper_ff[`AE_RA_HI:0]};
            if (!any_other) begin
              nxt_user = 1'b0;
            end
          end
        end
        `OP_STORE_HOLD: begin
          case (xsel)
            `XSEL_I: begin
              xval = index_i_ff;
            end
            `XSEL_J: begin
              xval = index_j_ff;
            end
            `XSEL_K: begin
              xval = index_k_ff;
            end
            default: begin
              // A refused store leaves the save word and the block alone
              nxt_err = 1'b1;
              nxt_block = block_ff;
              xval = save_ff;
            end
          endcase
          nxt_save = xval;
        end
        `OP_HOLD: begin
          if (user_ff) begin
            // Refused in user mode: no hold and no block
            nxt_err = 1'b1;
            nxt_block = block_ff;
          end else begin
            nxt_hold = 1'b1;
          end
        end
        `OP_RELEASE: begin
          if (user_ff) begin
            nxt_err = 1'b1;
            nxt_block = block_ff;
          end else begin
            nxt_hold = 1'b0;
            nxt_rel_pend = hold_ff;
          end
        end
        `OP_NEXT: begin
          nxt_block = 1'b0;
        end
        default: begin
          nxt_err = 1'b1;
          nxt_block = block_ff;
        end
      endcase
    end
  end

  always @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      oper_ff <= 24'h000000;
      index_i_ff <= 24'h000000;
      index_j_ff <= 24'h000000;
      index_k_ff <= 24'h000000;
      aem_ff <= 1'b0;
      user_ff <= 1'b0;
      cc_ff <= 4'h0;
      hold_ff <= 1'b0;
      block_ff <= 1'b0;
      rel_pend_ff <= 1'b0;
      err_ff <= 1'b0;
      save_ff <= 24'h000000;
      pc_ff <= 24'h000000;
      active_ff <= {LEVELS{1'b0}};
      trap_pend_ff <= 8'h00;
      trap_act_ff <= 8'h00;
    end else begin
      aem_ff <= nxt_aem;
      user_ff <= nxt_user;
      cc_ff <= nxt_cc;
      hold_ff <= nxt_hold;
      block_ff <= nxt_block;
      rel_pend_ff <= nxt_rel_pend;
      err_ff <= nxt_err;
      save_ff <= nxt_save;
      pc_ff <= nxt_pc;
      if (wr_en && PADDR_IN == `REG_OPER) begin
        oper_ff <= PWDATA_IN[23:0];
      end
      if (wr_en && PADDR_IN == `REG_INDEX) begin
        case (PWDATA_IN[25:24])
          `XSEL_I: index_i_ff <= PWDATA_IN[23:0];
          `XSEL_J: index_j_ff <= PWDATA_IN[23:0];
          `XSEL_K: index_k_ff <= PWDATA_IN[23:0];
          default: index_k_ff <= index_k_ff;
        endcase
      end
      // New activations win over a same-cycle reset
      active_ff <= (active_ff & ~clr_level) |
                   (LEVEL_ACTIVATE_IN & ~{LEVELS{EXT_BLOCK_OUT}});
      // held traps wait, then lowest first
      if (hold_ff) begin
        trap_pend_ff <= trap_pend_ff | (TRAP_TRIGGER_IN & `TRAP_HELD_MASK);
        trap_act_ff <= (trap_act_ff & ~clr_trap) | (TRAP_TRIGGER_IN & ~`TRAP_HELD_MASK);
      end else if (|trap_pend_ff) begin
        // Clearing the lowest set bit hands over one trap per cycle, level 5 first
        trap_pend_ff <= trap_pend_ff & (trap_pend_ff - 8'h01);
        trap_act_ff <= (trap_act_ff & ~clr_trap) | TRAP_TRIGGER_IN |
                       (trap_pend_ff & ~(trap_pend_ff - 8'h01));
      end else begin
        trap_act_ff <= (trap_act_ff & ~clr_trap) | TRAP_TRIGGER_IN;
      end
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    case (PADDR_IN)
      `REG_OPER: rd_mux = {8'h00, oper_ff};
      `REG_CTRL: rd_mux = {26'h0, cc_ff, user_ff, aem_ff};
      `REG_STATUS: rd_mux = {28'h0, user_ff, err_ff, block_ff, hold_ff};
      `REG_SAVE: rd_mux = {8'h00, save_ff};
      `REG_PC: rd_mux = {8'h00, pc_ff};
      `REG_ACTIVE: rd_mux = {{(32 - LEVELS){1'b0}}, active_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read data is captured in the setup phase, so the access phase sees a flop
  // and zero wait states are kept; a level activating meanwhile shows next read
  always @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PRDATA_OUT <= 32'h00000000;
    end else if (PSEL_IN && !PENABLE_IN) begin
      PRDATA_OUT <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ### hw/intr_entry_exit_defs.vh
`ifndef INTR_ENTRY_EXIT_DEFS_VH
`define INTR_ENTRY_EXIT_DEFS_VH

// APB register byte offsets
`define REG_CMD 12'h000
`define REG_OPER 12'h004
`define REG_CTRL 12'h008
`define REG_STATUS 12'h00c
`define REG_SAVE 12'h010
`define REG_PC 12'h014
`define REG_ACTIVE 12'h018
`define REG_INDEX 12'h01c

// Command codes written to REG_CMD bits 3:0
`define OP_SAVE_LONG 4'h1
`define OP_SAVE_EXT 4'h2
`define OP_RESET_BRANCH 4'h3
`define OP_STORE_HOLD 4'h4
`define OP_HOLD 4'h5
`define OP_RELEASE 4'h6
`define OP_NEXT 4'h7

// Field positions of the command word
`define CMD_OP_HI 3
`define CMD_OP_LO 0
`define CMD_IND_BIT 4
`define CMD_EXT_BIT 5
`define CMD_IDX_BIT 6
`define CMD_XSEL_HI 9
`define CMD_XSEL_LO 8

// Field positions of the control register
`define CTRL_AEM_BIT 0
`define CTRL_USER_BIT 1
`define CTRL_CC_HI 5
`define CTRL_CC_LO 2

// Save word layout
`define CM_USER_BIT 20
`define CM_CC_HI 19
`define CM_CC_LO 16
`define CM_RA_HI 15
`define AE_CC_HI 23
`define AE_CC_LO 20
`define AE_RA_HI 19

// Status bits
`define ST_HOLD 0
`define ST_BLOCK 1
`define ST_ERR 2
`define ST_USER 3

// Executive traps affected by the hold
`define TRAP_HELD_MASK 8'he0

// Encoded index select
`define XSEL_I 2'h1
`define XSEL_J 2'h2
`define XSEL_K 2'h3

`endif

// ### bench/intr_entry_exit_control_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "intr_entry_exit_defs.vh"
module intr_props #(parameter LEVELS = 24) (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [LEVELS-1:0] LEVEL_ACTIVE_OUT,
  input wire logic [7:0] TRAP_ACTIVE_OUT,
  input wire logic EXT_BLOCK_OUT,
  input wire logic HOLD_OUT,
  input wire logic USER_MODE_OUT,
  input wire logic [3:0] CC_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  wire cmd_wr = PSEL_IN & PENABLE_IN & PWRITE_IN & (PADDR_IN == `REG_CMD);
  wire [3:0] op = PWDATA_IN[3:0];
  property p_hold_set;
    cmd_wr && op == `OP_HOLD && !USER_MODE_OUT |=> HOLD_OUT;
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("hold not taken");
  property p_hold_keep;
    HOLD_OUT && !(cmd_wr && op == `OP_RELEASE) |=> HOLD_OUT;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("hold lost");
  property p_trap_held;
    HOLD_OUT |=> (TRAP_ACTIVE_OUT & ~$past(TRAP_ACTIVE_OUT) & `TRAP_HELD_MASK) == 8'h00;
  endproperty
  a_trap_held: assert property (p_trap_held) else $error("held trap rose");
  property p_lvl_blk;
    EXT_BLOCK_OUT |=> (LEVEL_ACTIVE_OUT & ~$past(LEVEL_ACTIVE_OUT)) == '0;
  endproperty
  a_lvl_blk: assert property (p_lvl_blk) else $error("level rose in block");
  property p_blk_set;
    cmd_wr && (op == `OP_SAVE_LONG || op == `OP_RESET_BRANCH) |=> EXT_BLOCK_OUT;
  endproperty
  a_blk_set: assert property (p_blk_set) else $error("no block after op");
  property p_cc_save;
    cmd_wr && (op == `OP_SAVE_LONG || op == `OP_SAVE_EXT) |=> $stable(CC_OUT);
  endproperty
  a_cc_save: assert property (p_cc_save) else $error("cc changed by save");
  property p_cc_direct_reset;
    cmd_wr && op == `OP_RESET_BRANCH && !PWDATA_IN[`CMD_IND_BIT] |=> $stable(CC_OUT);
  endproperty
  a_cc_direct_reset: assert property (p_cc_direct_reset) else $error("cc changed by direct reset");
  property p_reset_in_hold;
    cmd_wr && op == `OP_RESET_BRANCH && HOLD_OUT |=> $stable(LEVEL_ACTIVE_OUT);
  endproperty
  a_reset_in_hold: assert property (p_reset_in_hold) else $error("level reset in hold");
  property p_release;
    cmd_wr && op == `OP_RELEASE && HOLD_OUT && !USER_MODE_OUT |=> !HOLD_OUT ##0 EXT_BLOCK_OUT;
  endproperty
  a_release: assert property (p_release) else $error("release timing wrong");
endmodule
bind interrupt_entry_exit_control intr_props #(.LEVELS(LEVELS)) u_props (
  .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .LEVEL_ACTIVE_OUT(LEVEL_ACTIVE_OUT), .TRAP_ACTIVE_OUT(TRAP_ACTIVE_OUT),
  .EXT_BLOCK_OUT(EXT_BLOCK_OUT), .HOLD_OUT(HOLD_OUT), .USER_MODE_OUT(USER_MODE_OUT),
  .CC_OUT(CC_OUT));
`default_nettype wire

// ### bench/irq_system_model.sv
`timescale 1ns/1ps
`default_nettype none
module irq_system_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [23:0] raise_in,
  input wire logic [23:0] active_in,
  input wire logic [7:0] trap_in,
  input wire logic [23:0] mask_in,
  output logic [23:0] enable_out,
  output logic [23:0] request_out,
  output logic [7:0] trigger_out
);
  // Every level is enabled unless the bench masks it
  assign enable_out = ~mask_in;
  // A source keeps asking until its level is seen active, so a blocked request is not lost
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      request_out <= 24'h000000;
      trigger_out <= 8'h00;
    end else begin
      request_out <= (request_out | raise_in) & ~active_in;
      trigger_out <= trap_in;
    end
  end
endmodule
`default_nettype wire

// ### bench/test_interrupt_entry_exit_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "intr_entry_exit_defs.vh"
module test_interrupt_entry_exit_control;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdata;
  logic [23:0] raise = 24'h0, dis = 24'h0;
  logic [7:0] trap = 8'h00;
  wire [31:0] prdata;
  wire pready, blk, hold, user;
  wire [23:0] en, req, lvl;
  wire [7:0] trig, tact;
  wire [3:0] cc;
  int err_total = 0, num_checks = 0, cyc = 0;
  initial forever #25 clk = ~clk;
  irq_system_model pm (.clk_in(clk), .rst_in(rst), .raise_in(raise), .active_in(lvl),
    .trap_in(trap), .mask_in(dis), .enable_out(en), .request_out(req), .trigger_out(trig));
  interrupt_entry_exit_control dut (.MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(), .LEVEL_ENABLE_IN(en),
    .LEVEL_ACTIVATE_IN(req), .TRAP_TRIGGER_IN(trig), .LEVEL_ACTIVE_OUT(lvl),
    .TRAP_ACTIVE_OUT(tact), .EXT_BLOCK_OUT(blk), .HOLD_OUT(hold), .USER_MODE_OUT(user),
    .CC_OUT(cc));
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      end_sim;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Ends on a falling edge so the caller can look at settled outputs
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, rdata, e);
  endtask
  task automatic pulse(input logic [23:0] r, input logic [7:0] t);
    @(posedge clk);
    raise <= r;
    trap <= t;
    @(posedge clk);
    raise <= 24'h0;
    trap <= 8'h00;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_save;
    wr(`REG_OPER, 32'h001234);
    wr(`REG_CMD, 32'h03);
    rdc("pc", `REG_PC, 32'h001234);
    wr(`REG_CTRL, 32'h2a);
    wr(`REG_OPER, 32'h0f0200);
    wr(`REG_CMD, 32'h01);
    rdc("save", `REG_SAVE, 32'h001a1234);
    rdc("pc", `REG_PC, 32'h000201);
    chk("cc", cc, 4'ha);
    wr(`REG_CTRL, 32'h17);
    wr(`REG_OPER, 32'h012345);
    wr(`REG_CMD, 32'h02);
    xfer(1'b0, `REG_STATUS, 32'h0);
    chk("err", rdata[`ST_ERR], 1'b1);
    wr(`REG_CMD, 32'h22);
    rdc("save", `REG_SAVE, 32'h00500201);
    rdc("pc", `REG_PC, 32'h012346);
    wr(`REG_OPER, 32'h020000);
    wr(`REG_CMD, 32'h01);
    rdc("save", `REG_SAVE, 32'h00012346);
    wr(`REG_INDEX, 32'h03000010);
    wr(`REG_OPER, 32'h000300);
    wr(`REG_CMD, 32'h41);
    rdc("pc", `REG_PC, 32'h000301);
    wr(`REG_CMD, 32'h51);
    rdc("pc", `REG_PC, 32'h000311);
    for (int k = 1; k < 4; k++) begin
      wr(`REG_INDEX, {6'h0, k[1:0], 24'h00a0b0 + 24'(k)});
      wr(`REG_CMD, {22'h0, k[1:0], 8'h04});
      rdc("save", `REG_SAVE, {8'h0, 24'h00a0b0 + 24'(k)});
    end
  endtask
  task automatic t_reset_branch;
    wr(`REG_CTRL, 32'h00);
    wr(`REG_OPER, 32'h1f4321);
    wr(`REG_CMD, 32'h13);
    rdc("pc", `REG_PC, 32'h004321);
    chk("cc", cc, 4'hf);
    chk("user", user, 1'b1);
    wr(`REG_CTRL, 32'h03);
    wr(`REG_OPER, 32'h000400);
    wr(`REG_CMD, 32'h03);
    chk("user", user, 1'b1);
    rdc("pc", `REG_PC, 32'h000400);
    wr(`REG_OPER, 32'h7abcde);
    wr(`REG_CMD, 32'h13);
    rdc("pc", `REG_PC, 32'h0abcde);
    chk("cc", cc, 4'h7);
    chk("user", user, 1'b0);
  endtask
  task automatic t_hold;
    wr(`REG_CTRL, 32'h00);
    wr(`REG_CMD, 32'h01);
    chk("blk", blk, 1'b1);
    pulse(24'h000024, 8'h00);
    chk("lvl", lvl, 24'h0);
    wr(`REG_CMD, 32'h07);
    pulse(24'h0, 8'h00);
    chk("lvl", lvl, 24'h000024);
    // Level 2 masked: the reset must pass over it to level 5
    @(posedge clk);
    dis <= 24'h000004;
    wr(`REG_CMD, 32'h03);
    chk("lvl", lvl, 24'h000004);
    @(posedge clk);
    dis <= 24'h000000;
    wr(`REG_CMD, 32'h07);
    wr(`REG_CMD, 32'h05);
    chk("hold", hold, 1'b1);
    pulse(24'h0, 8'he2);
    chk("trap", tact, 8'h02);
    wr(`REG_CMD, 32'h03);
    chk("lvl", lvl, 24'h000004);
    chk("trap", tact, 8'h00);
    wr(`REG_CMD, 32'h06);
    chk("hold", hold, 1'b0);
    chk("blk", blk, 1'b1);
    @(negedge clk);
    chk("trap", tact, 8'h20);
    @(negedge clk);
    chk("trap", tact, 8'h60);
    wr(`REG_CMD, 32'h07);
    pulse(24'h000100, 8'h00);
    chk("blk", blk, 1'b0);
    chk("trap5", tact[5], 1'b1);
    chk("lvl", lvl, 24'h000104);
    wr(`REG_CTRL, 32'h03);
    wr(`REG_CMD, 32'h05);
    chk("hold", hold, 1'b0);
    wr(`REG_OPER, 32'h512345);
    wr(`REG_CMD, 32'h13);
    chk("user", user, 1'b1);
    chk("cc", cc, 4'h5);
    chk("lvl", lvl, 24'h000100);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_save;
    t_reset_branch;
    t_hold;
    end_sim;
  end
endmodule
`default_nettype wire
